// ===== design/sleep_sync_manager.sv
// Sleep synchronisation manager for one mesh node
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "sleep_sync_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sleep_sync_manager
  import sleep_sync_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `BUTTON_HOLD_CYCLES,
  parameter longint unsigned WAKE_CYCLES = `BUTTON_WAKE_CYCLES,
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  input  wire logic         button_n,
  input  wire logic         framed_host_mode,
  input  wire logic         sync_rx_valid,
  input  wire sync_msg_type sync_rx,
  input  wire logic         sync_req_rx,
  output logic              sync_tx_valid,
  output sync_msg_type      sync_tx,
  output logic              sync_req_tx,
  output logic              radio_awake,
  output logic              status_frame
);

  // ----------------------------------------------------------------
  // Registers and pin synchronisers
  // ----------------------------------------------------------------
  logic [31:0]    sleep_set_q;
  logic [31:0]    wake_set_q;
  logic [3:0]     mode_q;
  logic [31:0]    opt_q;
  logic [31:0]    op_sleep_q;
  logic [31:0]    op_wake_q;
  logic [15:0]    gen_q;
  logic           coord_q;
  logic           pend_q;
  logic [31:0]    missed_q;
  node_state_type state_q;
  logic [31:0]    phase_q;
  logic [31:0]    tick_div_q;
  logic [31:0]    hold_q;
  logic [32:0]    bwake_q;
  logic           new_sent_q;
  logic [1:0]     btn_sync_q;
  logic           tick;
  logic           compat;
  logic           support;
  logic           settings_write;
  logic [31:0]    early;
  logic [31:0]    eff_wake;
  logic [31:0]    eff_sleep;
  logic           rx_newer;
  logic           rx_older;
  logic           rx_take;
  logic           cycle_end;
  logic           wake_start;
  logic           go_sleep;
  logic           btn_wake;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      btn_sync_q <= 2'b00;
    else
      btn_sync_q <= {btn_sync_q[0], ~button_n};
  end

  assign compat         = (mode_q == `MODE_SUPPORT) || (mode_q == `MODE_CYCLIC);
  assign support        = mode_q == `MODE_SUPPORT;
  assign settings_write = reg_wr && ((reg_addr == `REG_SLEEP_SET) || (reg_addr == `REG_WAKE_SET));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_set_q <= `SLEEP_RESET;
      wake_set_q  <= `WAKE_RESET;
      mode_q      <= 4'h0;
      opt_q       <= `OPT_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `REG_SLEEP_SET: sleep_set_q <= reg_wdata;
        `REG_WAKE_SET:  wake_set_q  <= reg_wdata;
        `REG_MODE:      mode_q      <= reg_wdata[3:0];
        `REG_OPTIONS:   opt_q       <= {29'h0000_0000, reg_wdata[2:0]};
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_SLEEP_SET: reg_rdata <= sleep_set_q;
        `REG_WAKE_SET:  reg_rdata <= wake_set_q;
        `REG_MODE:      reg_rdata <= {28'h000_0000, mode_q};
        `REG_OPTIONS:   reg_rdata <= opt_q;
        `REG_OP_SLEEP:  reg_rdata <= op_sleep_q;
        `REG_OP_WAKE:   reg_rdata <= op_wake_q;
        `REG_STATUS:    reg_rdata <= {12'h000, gen_q, pend_q, state_q, coord_q};
        `REG_MISSED:    reg_rdata <= missed_q;
        default:        reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Tick divider, one pulse per millisecond
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_div_q <= 32'h0000_0000;
    else if (tick_div_q >= TICK_CYCLES - 1)
      tick_div_q <= 32'h0000_0000;
    else
      tick_div_q <= tick_div_q + 32'h0000_0001;
  end
  assign tick = tick_div_q >= TICK_CYCLES - 1;

  // ----------------------------------------------------------------
  // Early wake: shift part of sleep into wake per missed cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    early = 32'h0000_0000;
    if (opt_q[`OPT_EARLY_WAKE] && (state_q != UNSYNCED))
      early = missed_q * `EARLY_STEP_TICKS;
    if (early >= op_sleep_q)
      early = (op_sleep_q == 32'h0000_0000) ? 32'h0000_0000 : op_sleep_q - 32'h0000_0001;
    eff_wake  = op_wake_q + early;
    eff_sleep = op_sleep_q - early;
  end

  // Newer settings carry a higher generation; wrap is not handled
  assign rx_newer = sync_rx_valid && (sync_rx.generation > gen_q);
  assign rx_older = sync_rx_valid && (sync_rx.generation < gen_q);
  assign rx_take  = sync_rx_valid && !rx_older && !(coord_q && pend_q) && (state_q != ASLEEP);

  // ----------------------------------------------------------------
  // Button hold and button wake window
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_q <= 32'h0000_0000;
    else if (!btn_sync_q[1])
      hold_q <= 32'h0000_0000;
    else if (hold_q < HOLD_CYCLES)
      hold_q <= hold_q + 32'h0000_0001;
  end
  assign btn_wake = (hold_q == HOLD_CYCLES - 1) && (state_q == ASLEEP) && (mode_q == `MODE_CYCLIC);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      bwake_q <= 33'h0_0000_0000;
    else if (btn_wake)
      bwake_q <= 33'(WAKE_CYCLES);
    else if (bwake_q != 33'h0_0000_0000)
      bwake_q <= bwake_q - 33'h0_0000_0001;
  end

  // ----------------------------------------------------------------
  // Sleep/wake sequencer
  // ----------------------------------------------------------------
  assign cycle_end  = tick && (phase_q == 32'h0000_0000);
  assign wake_start = (state_q == ASLEEP) && cycle_end && (bwake_q == 33'h0_0000_0000);
  assign go_sleep   = (state_q == AWAKE) && cycle_end && !support && (bwake_q <= 33'h0_0000_0001);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= UNSYNCED;
      phase_q <= 32'h0000_0000;
    end
    else if (!compat)
    begin
      state_q <= UNSYNCED;
      phase_q <= 32'h0000_0000;
    end
    else if (rx_take)
    begin
      state_q <= AWAKE;
      phase_q <= sync_rx.wake_ticks;
    end
    else if (btn_wake)
      state_q <= AWAKE;
    else if (tick)
    begin
      case (state_q)
        UNSYNCED:
          phase_q <= (phase_q == 32'h0000_0000) ? sleep_set_q : phase_q - 32'h0000_0001;
        AWAKE:
          if (go_sleep)
          begin
            state_q <= ASLEEP;
            phase_q <= eff_sleep;
          end
          else if (phase_q != 32'h0000_0000)
            phase_q <= phase_q - 32'h0000_0001;
        ASLEEP:
          if (wake_start)
          begin
            state_q <= AWAKE;
            phase_q <= (coord_q && pend_q) ? wake_set_q : eff_wake;
          end
          else if (phase_q != 32'h0000_0000)
            phase_q <= phase_q - 32'h0000_0001;
        default:
          state_q <= UNSYNCED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operating settings, coordinator role, missed count
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_sleep_q <= `SLEEP_RESET;
      op_wake_q  <= `WAKE_RESET;
      gen_q      <= 16'h0000;
    end
    else if (rx_take)
    begin
      op_sleep_q <= sync_rx.sleep_ticks;
      op_wake_q  <= sync_rx.wake_ticks;
      gen_q      <= sync_rx.generation;
    end
    else if (new_sent_q)
    begin
      // Take what was really sent, so a write in flight cannot skew it
      op_sleep_q <= sync_tx.sleep_ticks;
      op_wake_q  <= sync_tx.wake_ticks;
      gen_q      <= sync_tx.generation;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coord_q <= 1'b0;
      pend_q  <= 1'b0;
    end
    else if (opt_q[`OPT_NON_COORD])
    begin
      coord_q <= 1'b0;
      pend_q  <= 1'b0;
    end
    else if (settings_write && compat)
    begin
      coord_q <= 1'b1;
      pend_q  <= 1'b1;
    end
    else if (new_sent_q)
      pend_q <= 1'b0;
    else if (rx_newer && !pend_q)
      coord_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      missed_q <= 32'h0000_0000;
    else if (rx_take)
      missed_q <= 32'h0000_0000;
    else if (wake_start && (missed_q != 32'hFFFF_FFFF))
      missed_q <= missed_q + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // Radio transmit requests and status frames
  // ----------------------------------------------------------------
  logic tx_fire;
  logic new_gen;
  // First edge of the next wake; an always-awake node sends at its next cycle end
  assign new_gen = coord_q && pend_q && (wake_start || (support && (state_q == AWAKE) && cycle_end));
  assign tx_fire = ((state_q == AWAKE) && sync_req_rx)
                 || (support && rx_older)
                 || new_gen;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_tx_valid <= 1'b0;
      sync_tx       <= '0;
      sync_req_tx   <= 1'b0;
      status_frame  <= 1'b0;
      radio_awake   <= 1'b0;
      new_sent_q    <= 1'b0;
    end
    else
    begin
      sync_tx_valid <= tx_fire && compat;
      new_sent_q    <= new_gen && compat;
      if (new_gen)
        sync_tx <= '{sleep_set_q, wake_set_q, gen_q + 16'h0001};
      else
        sync_tx <= '{op_sleep_q, op_wake_q, gen_q};
      sync_req_tx  <= compat && (state_q == UNSYNCED) && tick && (phase_q == 32'h0000_0000);
      status_frame <= opt_q[`OPT_STATUS_MSG] && framed_host_mode
                      && (wake_start || btn_wake || go_sleep);
      radio_awake  <= (state_q != ASLEEP) || support;
    end
  end

endmodule
`default_nettype wire

// ===== pkg/sleep_sync_defines.svh
// Constants for the sleep synchronisation manager
`ifndef SLEEP_SYNC_DEFINES_SVH
`define SLEEP_SYNC_DEFINES_SVH
`define CLK_FREQ_HZ          250000000
`define BUTTON_HOLD_MS       2000
`define BUTTON_HOLD_CYCLES   ((`CLK_FREQ_HZ / 1000) * `BUTTON_HOLD_MS)
`define BUTTON_WAKE_MS       30000
// The 30 s window overflows 32 bits at this clock, so it is reckoned in 64
`define BUTTON_WAKE_CYCLES   (64'(`CLK_FREQ_HZ / 1000) * `BUTTON_WAKE_MS)
`define TICK_US              1000
`define TICK_CYCLES          ((`CLK_FREQ_HZ / 1000000) * `TICK_US)
`define MODE_SUPPORT         4'h7
`define MODE_CYCLIC          4'h8
`define REG_SLEEP_SET        4'h0
`define REG_WAKE_SET         4'h1
`define REG_MODE             4'h2
`define REG_OPTIONS          4'h3
`define REG_OP_SLEEP         4'h4
`define REG_OP_WAKE          4'h5
`define REG_STATUS           4'h6
`define REG_MISSED           4'h7
`define OPT_NON_COORD        0
`define OPT_EARLY_WAKE       1
`define OPT_STATUS_MSG       2
`define OPT_RESET            32'h0000_0002
`define SLEEP_RESET          32'h0000_0064
`define WAKE_RESET           32'h0000_000A
`define EARLY_STEP_TICKS     32'h0000_0001
`endif

// ===== pkg/sleep_sync_pkg.sv
// Types for the sleep synchronisation manager
package sleep_sync_pkg;
  typedef struct packed {
    logic [31:0] sleep_ticks;
    logic [31:0] wake_ticks;
    logic [15:0] generation;
  } sync_msg_type;
  typedef enum logic [1:0] {UNSYNCED, AWAKE, ASLEEP} node_state_type;
endpackage

// ===== bench/sleep_sync_props.sv
// Port checker for the sleep synchronisation manager
`timescale 1ns/100ps
`default_nettype none
module sleep_sync_props
  import sleep_sync_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 20
)
(
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic [3:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata,
  input wire logic         button_n,
  input wire logic         framed_host_mode,
  input wire logic         sync_rx_valid,
  input wire sync_msg_type sync_rx,
  input wire logic         sync_req_rx,
  input wire logic         sync_tx_valid,
  input wire logic         sync_req_tx,
  input wire logic         radio_awake,
  input wire logic         status_frame
);
  // --------
  // Helpers
  // --------
  logic [3:0] mode_q;
  logic [7:0] hold_q;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      mode_q <= 4'h0;
    else if (reg_wr && reg_addr == 4'h2)
      mode_q <= reg_wdata[3:0];
  // Saturates so a long press never wraps back into range
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      hold_q <= 8'h00;
    else if (button_n)
      hold_q <= 8'h00;
    else if (hold_q != 8'hFF)
      hold_q <= hold_q + 8'h01;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_REQ_GAP: assert property (sync_req_tx |=> !sync_req_tx [*3])
    else $error("sync requests too close");
  AST_ANSWER: assert property (radio_awake && sync_req_rx |=> sync_tx_valid)
    else $error("sync request not answered");
  AST_SUPPORT: assert property (mode_q == 4'h7 && $past(mode_q == 4'h7, 3) |-> radio_awake)
    else $error("support node asleep");
  AST_BUTTON: assert property (mode_q == 4'h8 && hold_q == HOLD_CYCLES + 6 |-> radio_awake)
    else $error("button hold did not wake");
  AST_OP_SLEEP: assert property (sync_rx_valid ##1 (reg_rd && reg_addr == 4'h4)
    |=> reg_rdata == $past(sync_rx.sleep_ticks, 2)) else $error("sleep time not taken from sync");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  AST_FRAME: assert property (status_frame |-> framed_host_mode || $past(framed_host_mode))
    else $error("status frame outside framed mode");
  AST_MISS_CLR: assert property ($past(sync_rx_valid, 3) && reg_rd && reg_addr == 4'h7
    |=> reg_rdata == 32'h0000_0000) else $error("missed count not cleared");
  COV_ANSWER: cover property (radio_awake && sync_req_rx);
  COV_TX: cover property (sync_tx_valid);
  COV_FRAME: cover property (status_frame);
endmodule
`default_nettype wire

// ===== bench/sync_peer.sv
// Peer node model on the radio side
`timescale 1ns/100ps
`default_nettype none
module sync_peer
  import sleep_sync_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         sync_req_tx,
  input  wire logic         answer_en,
  input  wire logic         slow,
  input  wire logic         push,
  input  wire logic         ask,
  input  wire sync_msg_type msg,
  output logic              sync_rx_valid,
  output sync_msg_type      sync_rx,
  output logic              sync_req_rx
);
  logic req_q;
  logic fire;
  // Slow mode answers one cycle later than prompt mode
  assign fire = push || (answer_en && (slow ? req_q : sync_req_tx));
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      req_q <= 1'b0;
      sync_rx_valid <= 1'b0;
      sync_rx <= '0;
      sync_req_rx <= 1'b0;
    end
    else
    begin
      req_q <= sync_req_tx;
      sync_rx_valid <= fire;
      // Idle payload toggles so stale data is never mistaken for a sync
      sync_rx <= fire ? msg : ~sync_rx;
      sync_req_rx <= ask;
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking testbench for the sleep synchronisation manager
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sleep_sync_pkg::*;
;
  localparam int unsigned HOLD = 20;
  localparam int unsigned WAKE = 100;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, button_n = 1'b1;
  logic framed_host_mode = 1'b0, ans = 1'b0, slow = 1'b0, push = 1'b0, ask = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  sync_msg_type msg = '0, sync_rx, sync_tx;
  logic sync_rx_valid, sync_req_rx, sync_tx_valid, sync_req_tx, radio_awake, status_frame;
  int mismatches = 0, checks = 0, cyc = 0, n;
  sleep_sync_manager #(.HOLD_CYCLES(HOLD), .WAKE_CYCLES(WAKE), .TICK_CYCLES(4)) dut_u (.sys_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .button_n, .framed_host_mode, .sync_rx_valid,
    .sync_rx, .sync_req_rx, .sync_tx_valid, .sync_tx, .sync_req_tx, .radio_awake, .status_frame);
  sync_peer peer_u (.sys_clk, .rst_n, .sync_req_tx, .answer_en(ans), .slow, .push, .ask, .msg,
    .sync_rx_valid, .sync_rx, .sync_req_rx);
  always #2 sys_clk = ~sys_clk;
  // --------
  // Tasks
  // --------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask
  // Bounded wait, the caller's compare catches a miss
  task automatic wt(input int w, input int lim);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while ((w == 0 ? sync_req_tx : w == 1 ? sync_rx_valid : w == 2 ? sync_tx_valid :
            w == 3 ? status_frame : !radio_awake) !== 1'b1 && n < lim);
  endtask
  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize;
    end
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rc(4'h3, 32'h0000_0002, "options");
    rc(4'h0, 32'h0000_0064, "sleep_set");
    rc(4'h7, 32'h0000_0000, "missed");
    rc(4'h8, 32'h0000_0000, "unmapped");
    wr(4'h2, 32'h0000_0008);
    msg <= {32'h0000_0006, 32'h0000_0003, 16'h0005};
    ans <= 1'b1;
    slow <= 1'b1;
    wt(0, 500);
    chk("request", 32'h1, {31'h0, sync_req_tx});
    wt(1, 8);
    rc(4'h4, 32'h0000_0006, "op_sleep");
    rc(4'h7, 32'h0000_0000, "missed");
    rc(4'h5, 32'h0000_0003, "op_wake");
    rd(4'h6);
    chk("gen", 32'h5, {16'h0, d[19:4]});
    chk("coord", 32'h0, {31'h0, d[0]});
    ans <= 1'b0;
    repeat (300) @(posedge sys_clk);
    rd(4'h7);
    chk("missed_grows", 32'h1, {31'h0, d != 32'h0});
    wr(4'h0, 32'h0000_0001);
    wr(4'h1, 32'h0000_0002);
    rd(4'h6);
    chk("coord", 32'h1, {31'h0, d[0]});
    wt(2, 400);
    chk("tx_sleep", 32'h1, sync_tx.sleep_ticks);
    chk("tx_wake", 32'h2, sync_tx.wake_ticks);
    chk("tx_gen", 32'h6, {16'h0, sync_tx.generation});
    rc(4'h5, 32'h0000_0002, "op_wake");
    wr(4'h3, 32'hFFFF_FFFF);
    rc(4'h3, 32'h0000_0007, "options");
    rd(4'h6);
    chk("coord_off", 32'h0, {31'h0, d[0]});
    framed_host_mode <= 1'b1;
    wt(3, 400);
    chk("frame", 32'h1, {31'h0, status_frame});
    wr(4'h2, 32'h0000_0007);
    repeat (40) @(posedge sys_clk);
    chk("awake", 32'h1, {31'h0, radio_awake});
    ask <= 1'b1;
    @(posedge sys_clk);
    ask <= 1'b0;
    wt(2, 4);
    chk("answer", 32'h1, {31'h0, sync_tx_valid});
    msg <= {32'h0000_0006, 32'h0000_0003, 16'h0001};
    push <= 1'b1;
    @(posedge sys_clk);
    push <= 1'b0;
    wt(2, 20);
    chk("reply_gen", 32'h6, {16'h0, sync_tx.generation});
    wr(4'h3, 32'h0000_0002);
    wr(4'h2, 32'h0000_0008);
    wr(4'h0, 32'h0000_003C);
    wt(2, 400);
    chk("tx_sleep2", 32'h3C, sync_tx.sleep_ticks);
    chk("tx_gen2", 32'h7, {16'h0, sync_tx.generation});
    wt(4, 400);
    chk("asleep", 32'h0, {31'h0, radio_awake});
    button_n <= 1'b0;
    repeat (HOLD + 6) @(posedge sys_clk);
    chk("button_wake", 32'h1, {31'h0, radio_awake});
    button_n <= 1'b1;
    repeat (WAKE - 20) @(posedge sys_clk);
    chk("wake_hold", 32'h1, {31'h0, radio_awake});
    summarize;
  end
endmodule
bind sleep_sync_manager sleep_sync_props #(.HOLD_CYCLES(HOLD_CYCLES)) props_u (.sys_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .button_n, .framed_host_mode, .sync_rx_valid, .sync_rx,
  .sync_req_rx, .sync_tx_valid, .sync_req_tx, .radio_awake, .status_frame);
`default_nettype wire
